/* hdl/php_pkg.sv */
// Shared constants and types for the host power and status register block
package php_pkg;

    // Host access spaces, one-hot
    typedef enum logic [3:0] {
        SP_CFG  = 4'h1,
        SP_IO   = 4'h2,
        SP_MEM1 = 4'h4,
        SP_MEM0 = 4'h8
    } php_space_t;

    localparam int ADDR_W = 8;

    // Configuration dword holding power control/status and power data
    localparam logic [ADDR_W-1:0] CFG_PM_CTRL_OFS = 8'h44;

    // Host register block, I/O space and second memory window
    localparam logic [3:0] HOST_STATUS_OFS = 4'h0;
    localparam logic [3:0] HOST_TO_DSP_CONTROL_OFS = 4'h4;
    localparam logic [3:0] DSP_PAGE_WINDOW_OFS = 4'h8;
    localparam logic [3:0] HOST_RSVD_OFS = 4'hc;

    // Power control/status field positions
    localparam int PM_STATE_LSB = 0;
    localparam int PM_WAKE_EN_BIT = 8;
    localparam int PM_SEL_LSB = 9;
    localparam int PM_SCALE_LSB = 13;
    localparam int PM_WAKE_STAT_BIT = 15;
    localparam int PWR_DATA_LSB = 24;

    // Host status field positions
    localparam int HS_SRC_BIT = 0;
    localparam int HS_PIN_BIT = 1;
    localparam int HS_MASK_BIT = 2;
    localparam int HS_ERR_BIT = 3;
    localparam int HS_EE_BIT = 4;

    // Power states
    localparam logic [1:0] PS_D0 = 2'h0;
    localparam logic [1:0] PS_D1 = 2'h1;
    localparam logic [1:0] PS_D2 = 2'h2;
    localparam logic [1:0] PS_D3 = 2'h3;

    // Power data scale codes; zero is reserved
    localparam logic [1:0] SCALE_RSVD = 2'h0;
    localparam logic [1:0] SCALE_TENTH = 2'h1;
    localparam logic [1:0] SCALE_HUNDREDTH = 2'h2;
    localparam logic [1:0] SCALE_THOUSANDTH = 2'h3;

    // Power table geometry
    localparam int TBL_DEPTH = 8;
    localparam int TBL_IDX_W = 3;
    localparam int PWR_W = 8;
    localparam logic [PWR_W-1:0] PWR_RESET = 8'h00;

endpackage

/* hdl/php_tbl_if.sv */
// Carrier between the register logic and the power data table
`timescale 1ns/100ps
interface php_tbl_if;
    logic wr_en;
    logic [2:0] wr_idx;
    logic [7:0] wr_data;
    logic [1:0] wr_scale;
    logic [2:0] rd_idx;
    logic rd_zero;
    logic [7:0] rd_data;
    logic [1:0] rd_scale;

    modport owner (
        output wr_en, wr_idx, wr_data, wr_scale, rd_idx, rd_zero,
        input rd_data, rd_scale
    );
    modport table_side (
        input wr_en, wr_idx, wr_data, wr_scale, rd_idx, rd_zero,
        output rd_data, rd_scale
    );
endinterface

/* hdl/php_pwr_table.sv */
// Power consumed and dissipated table with registered read
`timescale 1ns/100ps
module php_pwr_table
    import php_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    php_tbl_if.table_side tbl
);

    typedef struct packed {
        logic [1:0] scale;
        logic [PWR_W-1:0] data;
    } php_entry_t;

    typedef struct packed {
        php_entry_t [TBL_DEPTH-1:0] ent;
        logic [PWR_W-1:0] rd_data;
        logic [1:0] rd_scale;
    } php_tbl_state_t;

    php_tbl_state_t q, d;

    always_comb begin
        d = q;
        for (int i = 0; i < TBL_DEPTH; i++) begin
            if (tbl.wr_en && tbl.wr_idx == i[TBL_IDX_W-1:0]) begin
                d.ent[i].data = tbl.wr_data;
                d.ent[i].scale = tbl.wr_scale;
            end
        end
        // Unused select codes give zero data and reserved scale
        if (tbl.rd_zero) begin
            d.rd_data = PWR_RESET;
            d.rd_scale = SCALE_RSVD;
        end else begin
            d.rd_data = q.ent[tbl.rd_idx].data;
            d.rd_scale = q.ent[tbl.rd_idx].scale;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < TBL_DEPTH; i++) begin
                q.ent[i].data <= PWR_RESET;
                q.ent[i].scale <= SCALE_TENTH;
            end
            q.rd_data <= PWR_RESET;
            q.rd_scale <= SCALE_RSVD;
        end else begin
            q <= d;
        end
    end

    assign tbl.rd_data = q.rd_data;
    assign tbl.rd_scale = q.rd_scale;

endmodule

/* hdl/php_regs.sv */
// Host power management and host status register logic
//
// How it works
// - Scale field reports tenths, hundredths, thousandths watt
// - Select field picks power data and scale
// - Selects 0-3 give power consumed D0-D3hot
// - Selects 8-B give power dissipated D0-D3hot
// - Selects 4-7 and C-F read zero
// - Wake enable gates the wake pin
// - Control bits 7:2 read zero, ignore writes
// - State field reads DSP current state
// - Changed state write stores request, pulses DSP
// - Unchanged state write raises nothing
// - Illegal state writes complete but are discarded
// - Status 00h, control 04h, page 08h decode
// - Byte-granular access, host side only
// - Second memory window reaches host registers
// - First memory window goes to DSP registers
// - Bit 4 shows configuration loaded from EEPROM
// - Bit 3 shows autoinit error, read only
// - Mask bit and low power block pin
// - Bit 1 mirrors live interrupt pin
// - Source bit sets on armed, unmasked request, write-one clears
// - Clearing source does not re-arm interrupts
// - DSP request asserts pin only when unmasked
// - DSP re-arm deasserts pin and re-arms logic
// - Wake status and enable drive wake pin
`timescale 1ns/100ps
module php_regs
    import php_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic host_req,
    input wire logic host_wr,
    input wire php_space_t host_space,
    input wire logic [ADDR_W-1:0] host_addr,
    input wire logic [3:0] host_be,
    input wire logic [31:0] host_wdata,
    output logic host_ack,
    output logic [31:0] host_rdata,
    output logic dsp_mmr_req,
    output logic [ADDR_W-1:0] dsp_mmr_addr,
    input wire logic dsp_irq_request,
    input wire logic irq_logic_rearm,
    input wire logic [1:0] current_power_state,
    input wire logic wake_event_in,
    input wire logic loaded_from_eeprom,
    input wire logic autoinit_error,
    input wire logic tbl_wr,
    input wire logic [2:0] tbl_idx,
    input wire logic [7:0] tbl_data,
    input wire logic [1:0] tbl_scale,
    output logic pwr_change_pulse,
    output logic [1:0] requested_power_state,
    output logic host_irq_pin_o,
    output logic host_irq_pin_oe,
    output logic wake_pin_o,
    output logic wake_pin_oe,
    output logic [31:0] host_to_dsp_control,
    output logic [31:0] dsp_page_window
);

    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic mmr_req;
        logic [ADDR_W-1:0] mmr_addr;
        logic mask;
        logic src;
        logic active;
        logic armed;
        logic [1:0] req_state;
        logic [1:0] cur_state;
        logic chg;
        logic wake_en;
        logic wake_stat;
        logic [3:0] sel;
        logic ee;
        logic err;
        logic irq_oe;
        logic wake_oe;
        logic [31:0] ctl;
        logic [31:0] page;
        // Open-drain data levels; the pins only ever pull low
        logic irq_lvl;
        logic wake_lvl;
    } php_state_t;

    localparam php_state_t RESET_STATE = '{
        ack: 1'b0,
        rdata: 32'h0000_0000,
        mmr_req: 1'b0,
        mmr_addr: 8'h00,
        mask: 1'b0,
        src: 1'b0,
        active: 1'b0,
        armed: 1'b1,
        req_state: PS_D0,
        cur_state: PS_D0,
        chg: 1'b0,
        wake_en: 1'b0,
        wake_stat: 1'b0,
        sel: 4'h0,
        ee: 1'b0,
        err: 1'b0,
        irq_oe: 1'b0,
        wake_oe: 1'b0,
        ctl: 32'h0000_0000,
        page: 32'h0000_0000,
        irq_lvl: 1'b0,
        wake_lvl: 1'b0
    };

    php_state_t q, d;
    php_tbl_if tbl();

    logic host_hit;
    logic cfg_hit;
    logic [1:0] new_state;
    logic state_legal;
    logic [31:0] pm_word;
    logic [31:0] host_word;
    logic [3:0] sel_next;
    logic hs_wr;
    logic ctl_wr;
    logic page_wr;
    logic pm_lo_wr;
    logic pm_hi_wr;

    php_pwr_table u_table (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .tbl(tbl.table_side)
    );

    // Table follows the next select so reads after a select write are fresh
    assign tbl.wr_en = tbl_wr;
    assign tbl.wr_idx = tbl_idx;
    assign tbl.wr_data = tbl_data;
    assign tbl.wr_scale = tbl_scale;
    assign tbl.rd_idx = {sel_next[3], sel_next[1:0]};
    assign tbl.rd_zero = sel_next[2];

    // Host register block is reached from I/O space or the second window only
    assign host_hit = host_req && (host_space == SP_IO || host_space == SP_MEM1);
    assign cfg_hit = host_req && host_space == SP_CFG
        && host_addr[ADDR_W-1:2] == CFG_PM_CTRL_OFS[ADDR_W-1:2];
    assign new_state = host_wdata[PM_STATE_LSB +: 2];
    // Only D0 and D3hot are supported, so only those requests are processed
    assign state_legal = (new_state == PS_D0) || (new_state == PS_D3);

    // Write qualifiers, one per writable field group
    assign hs_wr = host_hit && host_wr && host_addr[3:0] == HOST_STATUS_OFS
        && host_be[0];
    assign ctl_wr = host_hit && host_wr && host_addr[3:0] == HOST_TO_DSP_CONTROL_OFS;
    assign page_wr = host_hit && host_wr && host_addr[3:0] == DSP_PAGE_WINDOW_OFS;
    // State lives in byte 0; enable, select and wake status in byte 1
    assign pm_lo_wr = cfg_hit && host_wr && host_be[0];
    assign pm_hi_wr = cfg_hit && host_wr && host_be[1];

    always_comb begin
        sel_next = q.sel;
        if (pm_hi_wr) begin
            sel_next = host_wdata[PM_SEL_LSB +: 4];
        end
    end

    always_comb begin
        pm_word = 32'h0000_0000;
        pm_word[PM_STATE_LSB +: 2] = q.cur_state;
        pm_word[PM_WAKE_EN_BIT] = q.wake_en;
        pm_word[PM_SEL_LSB +: 4] = q.sel;
        pm_word[PM_SCALE_LSB +: 2] = tbl.rd_scale;
        pm_word[PM_WAKE_STAT_BIT] = q.wake_stat;
        pm_word[PWR_DATA_LSB +: PWR_W] = tbl.rd_data;
    end

    always_comb begin
        host_word = 32'h0000_0000;
        case (host_addr[3:0])
            HOST_STATUS_OFS: begin
                host_word[HS_SRC_BIT] = q.src;
                host_word[HS_PIN_BIT] = q.irq_oe;
                host_word[HS_MASK_BIT] = q.mask;
                host_word[HS_ERR_BIT] = q.err;
                host_word[HS_EE_BIT] = q.ee;
            end
            HOST_TO_DSP_CONTROL_OFS: host_word = q.ctl;
            DSP_PAGE_WINDOW_OFS: host_word = q.page;
            default: host_word = 32'h0000_0000;
        endcase
    end

    always_comb begin
        d = q;
        d.ack = 1'b0;
        d.mmr_req = 1'b0;
        d.chg = 1'b0;
        // Registered copy feeds the read-back; the pin mask takes the incoming state directly
        d.cur_state = current_power_state;
        // Strap-like status follows its source; reset forces zero
        d.ee = loaded_from_eeprom;
        d.err = autoinit_error;

        // First window goes to the DSP registers, not handled here
        if (host_req && host_space == SP_MEM0) begin
            d.mmr_req = 1'b1;
            d.mmr_addr = host_addr;
        end

        if (host_req && host_space != SP_MEM0) begin
            d.ack = 1'b1;
            if (host_wr) begin
                d.rdata = 32'h0000_0000;
            end else if (host_hit) begin
                d.rdata = host_word;
            end else if (cfg_hit) begin
                d.rdata = pm_word;
            end else begin
                d.rdata = 32'h0000_0000;
            end
        end

        // Host status writes: mask, write-one clear of source
        if (hs_wr) begin
            d.mask = host_wdata[HS_MASK_BIT];
            if (host_wdata[HS_SRC_BIT]) begin
                // Pin drops but the logic stays disarmed
                d.src = 1'b0;
                d.active = 1'b0;
            end
        end

        // Byte lanes of the two plain host registers
        for (int b = 0; b < 4; b++) begin
            if (host_be[b]) begin
                if (ctl_wr) begin
                    d.ctl[8*b +: 8] = host_wdata[8*b +: 8];
                end
                if (page_wr) begin
                    d.page[8*b +: 8] = host_wdata[8*b +: 8];
                end
            end
        end

        if (irq_logic_rearm) begin
            d.active = 1'b0;
            d.armed = 1'b1;
        end
        // Request after clears so a simultaneous event is not lost
        if (dsp_irq_request && q.armed && !q.mask) begin
            d.src = 1'b1;
            d.active = 1'b1;
            d.armed = 1'b0;
        end

        // Power control/status writes
        if (pm_lo_wr) begin
            if (new_state != q.req_state && state_legal) begin
                d.req_state = new_state;
                d.chg = 1'b1;
            end
        end
        if (pm_hi_wr) begin
            d.wake_en = host_wdata[PM_WAKE_EN_BIT];
            d.sel = sel_next;
            if (host_wdata[PM_WAKE_STAT_BIT]) begin
                d.wake_stat = 1'b0;
            end
        end
        if (wake_event_in) begin
            d.wake_stat = 1'b1;
        end

        // Mask and low power states block the pin without touching the logic
        d.irq_oe = d.active && !d.mask && (d.cur_state == PS_D0);
        d.wake_oe = d.wake_stat && d.wake_en;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= RESET_STATE;
        end else begin
            q <= d;
        end
    end

    // Open-drain pins only ever pull low
    assign host_ack = q.ack;
    assign host_rdata = q.rdata;
    assign dsp_mmr_req = q.mmr_req;
    assign dsp_mmr_addr = q.mmr_addr;
    assign pwr_change_pulse = q.chg;
    assign requested_power_state = q.req_state;
    assign host_irq_pin_o = q.irq_lvl;
    assign host_irq_pin_oe = q.irq_oe;
    assign wake_pin_o = q.wake_lvl;
    assign wake_pin_oe = q.wake_oe;
    assign host_to_dsp_control = q.ctl;
    assign dsp_page_window = q.page;

endmodule

/* bench/php_host_model.sv */
// Host bus master model issuing single-cycle register requests
`timescale 1ns/100ps
module php_host_model
    import php_pkg::*;
(
    input wire logic core_clk,
    output logic host_req,
    output logic host_wr,
    output php_space_t host_space,
    output logic [ADDR_W-1:0] host_addr,
    output logic [3:0] host_be,
    output logic [31:0] host_wdata,
    input wire logic [31:0] host_rdata
);
    initial begin
        host_req = 1'b0;
        host_wr = 1'b0;
        host_space = SP_IO;
        host_addr = 8'h00;
        host_be = 4'h0;
        host_wdata = 32'h0;
    end

    // One request, answer one cycle later; released address and write data scramble
    task automatic acc(input logic wr, input php_space_t sp, input logic [7:0] a,
        input logic [3:0] be, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge core_clk);
        #1;
        host_req = 1'b1;
        host_wr = wr;
        host_space = sp;
        host_addr = a;
        host_be = be;
        host_wdata = wd;
        @(posedge core_clk);
        #1;
        host_req = 1'b0;
        host_addr = ~a;
        host_wdata = ~wd;
        rd = host_rdata;
    endtask
endmodule

/* bench/php_regs_asserts.sv */
// Concurrent checks on the host power and status register ports
`timescale 1ns/100ps
module php_regs_asserts
    import php_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic host_req,
    input wire logic host_wr,
    input wire php_space_t host_space,
    input wire logic [ADDR_W-1:0] host_addr,
    input wire logic [3:0] host_be,
    input wire logic [31:0] host_wdata,
    input wire logic host_ack,
    input wire logic [31:0] host_rdata,
    input wire logic dsp_mmr_req,
    input wire logic [ADDR_W-1:0] dsp_mmr_addr,
    input wire logic dsp_irq_request,
    input wire logic irq_logic_rearm,
    input wire logic [1:0] current_power_state,
    input wire logic pwr_change_pulse,
    input wire logic [1:0] requested_power_state,
    input wire logic host_irq_pin_oe
);
    logic st_wr;
    logic [1:0] ps_w;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    assign ps_w = host_wdata[1:0];
    assign st_wr = host_req && host_wr && host_space == SP_CFG
        && host_addr == CFG_PM_CTRL_OFS && host_be[0];

    AST_ACK_NEXT: assert property (host_req && host_space != SP_MEM0 |=> host_ack)
        else $error("host request not acknowledged");
    AST_MEM0_FWD: assert property (host_req && host_space == SP_MEM0 |=>
        dsp_mmr_req && !host_ack && dsp_mmr_addr == $past(host_addr))
        else $error("first window access not forwarded");
    AST_ACK_CAUSE: assert property (host_ack |-> $past(host_req))
        else $error("ack without request");
    AST_RDATA_HOLD: assert property (!host_ack |-> $stable(host_rdata))
        else $error("read data moved without ack");
    AST_PULSE_CAUSE: assert property (pwr_change_pulse |-> $past(st_wr)
        && requested_power_state != $past(requested_power_state))
        else $error("state pulse without changed write");
    AST_SAME_QUIET: assert property (st_wr && ps_w == requested_power_state
        |=> !pwr_change_pulse) else $error("pulse on unchanged state write");
    AST_ILLEGAL_QUIET: assert property (st_wr && (ps_w == PS_D1 || ps_w == PS_D2)
        |=> !pwr_change_pulse && $stable(requested_power_state))
        else $error("unsupported state accepted");
    AST_LEGAL_PULSE: assert property (st_wr && (ps_w == PS_D0 || ps_w == PS_D3)
        && ps_w != requested_power_state |=> pwr_change_pulse
        && requested_power_state == $past(ps_w)) else $error("legal state change lost");
    AST_LOWPWR_MASK: assert property ((current_power_state != PS_D0)[*2]
        |-> !host_irq_pin_oe) else $error("interrupt pin driven in low power");
    AST_REARM_DROP: assert property (irq_logic_rearm && !dsp_irq_request
        |=> !host_irq_pin_oe) else $error("pin held after rearm");
    cover property (pwr_change_pulse);
    cover property (host_irq_pin_oe ##1 !host_irq_pin_oe);
    cover property (dsp_mmr_req);
endmodule

bind php_regs php_regs_asserts php_regs_asserts_i (.core_clk, .rst_n, .host_req, .host_wr,
    .host_space, .host_addr, .host_be, .host_wdata, .host_ack, .host_rdata, .dsp_mmr_req,
    .dsp_mmr_addr, .dsp_irq_request, .irq_logic_rearm, .current_power_state,
    .pwr_change_pulse, .requested_power_state, .host_irq_pin_oe);

/* bench/tb_php_regs.sv */
// Self-checking bench for the host power and status register block
`timescale 1ns/100ps
module tb_php_regs
    import php_pkg::*;
;
    logic core_clk, rst_n, host_req, host_wr, host_ack, dsp_mmr_req, tbl_wr, ee, err;
    php_space_t host_space, sp;
    logic [7:0] host_addr, dsp_mmr_addr, tbl_data;
    logic [3:0] host_be, sel;
    logic [31:0] host_wdata, host_rdata, host_to_dsp_control, dsp_page_window, r, rd;
    logic [2:0] ev, tbl_idx;
    logic [1:0] cur, tbl_scale, requested_power_state, mreq, ps;
    logic pwr_change_pulse, host_irq_pin_o, host_irq_pin_oe, wake_pin_o, wake_pin_oe;
    logic [7:0] td [8];
    logic [1:0] ts [8];
    logic [1:0] pl [5] = '{PS_D3, PS_D3, PS_D1, PS_D2, PS_D0};
    logic [31:0] seed = 32'h4df1243f;
    int miscompares = 0, n_checks = 0, npulse = 0, mcnt = 0;

    php_host_model php_host_model_i (.core_clk, .host_req, .host_wr, .host_space,
        .host_addr, .host_be, .host_wdata, .host_rdata);
    php_regs php_regs_i (.core_clk, .rst_n, .host_req, .host_wr, .host_space, .host_addr,
        .host_be, .host_wdata, .host_ack, .host_rdata, .dsp_mmr_req, .dsp_mmr_addr,
        .dsp_irq_request(ev[0]), .irq_logic_rearm(ev[1]), .current_power_state(cur),
        .wake_event_in(ev[2]), .loaded_from_eeprom(ee), .autoinit_error(err), .tbl_wr,
        .tbl_idx, .tbl_data, .tbl_scale, .pwr_change_pulse, .requested_power_state,
        .host_irq_pin_o, .host_irq_pin_oe, .wake_pin_o, .wake_pin_oe, .host_to_dsp_control,
        .dsp_page_window);

    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Power dword as the host should see it, wake bits clear
    function automatic logic [31:0] exp_pm(input logic [3:0] s, input logic [1:0] c);
        logic [2:0] ix;
        ix = {s[3], s[1:0]};
        if (s[2])
            return {19'h0, s, 7'h0, c};
        return {td[ix], 9'h0, ts[ix], s, 7'h0, c};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic close_out();
        $display("checks=%0d miscompares=%0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic ev_pulse(input int b);
        @(posedge core_clk);
        #1;
        ev[b] = 1'b1;
        @(posedge core_clk);
        #1;
        ev[b] = 1'b0;
    endtask

    task automatic wr(input php_space_t s, input logic [3:0] a, input logic [31:0] d);
        php_host_model_i.acc(1'b1, s, {4'h0, a}, 4'h1, d, rd);
    endtask

    task automatic st(input logic [2:0] lo);
        php_host_model_i.acc(1'b0, sp, {4'h0, HOST_STATUS_OFS}, 4'hf, 32'h0, rd);
        chk(rd, {27'h0, ee, err, lo});
    endtask

    always @(negedge core_clk)
        if (pwr_change_pulse === 1'b1)
            npulse++;

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    // About 200 cycles of work; twenty times that means a hang
    initial begin
        #(50 * 4000);
        miscompares++;
        close_out();
    end

    initial begin
        rst_n = 1'b0;
        {ev, cur, tbl_wr, tbl_idx, tbl_data, tbl_scale} = '0;
        r = rnd();
        {ee, err} = r[1:0];
        repeat (8) @(posedge core_clk);
        #1;
        rst_n = 1'b1;
        for (int i = 0; i < 8; i++) begin
            r = rnd();
            td[i] = r[7:0];
            ts[i] = (r[9:8] == 2'h0) ? SCALE_TENTH : r[9:8];
            @(posedge core_clk);
            #1;
            {tbl_wr, tbl_idx, tbl_data, tbl_scale} = {1'b1, 3'(i), td[i], ts[i]};
        end
        @(posedge core_clk);
        #1;
        tbl_wr = 1'b0;
        for (int i = 0; i < 16; i++) begin
            r = rnd();
            sel = 4'(i);
            cur = sel[1:0];
            php_host_model_i.acc(1'b1, SP_CFG, CFG_PM_CTRL_OFS, 4'h3,
                {19'h0, sel, 1'b0, r[5:0], 2'h0}, rd);
            php_host_model_i.acc(1'b0, SP_CFG, CFG_PM_CTRL_OFS, 4'hf, 32'h0, rd);
            chk(rd, exp_pm(sel, cur));
        end
        cur = PS_D0;
        mreq = PS_D0;
        for (int j = 0; j < 9; j++) begin
            r = rnd();
            ps = (j < 5) ? pl[j] : r[1:0];
            if ((ps == PS_D0 || ps == PS_D3) && ps != mreq) begin
                mreq = ps;
                mcnt++;
            end
            php_host_model_i.acc(1'b1, SP_CFG, CFG_PM_CTRL_OFS, 4'h1, {30'h0, ps}, rd);
            @(posedge core_clk);
            #1;
            chk({30'h0, requested_power_state}, {30'h0, mreq});
            chk(32'(npulse), 32'(mcnt));
        end
        for (int k = 0; k < 2; k++) begin
            sp = k ? SP_MEM1 : SP_IO;
            ev_pulse(0);
            st(3'h3);
            wr(sp, HOST_STATUS_OFS, 32'h1);
            ev_pulse(0);
            st(3'h0);
            ev_pulse(1);
            wr(sp, HOST_STATUS_OFS, 32'h4);
            ev_pulse(0);
            st(3'h4);
            wr(sp, HOST_STATUS_OFS, 32'h0);
            ev_pulse(0);
            wr(sp, HOST_STATUS_OFS, 32'h4);
            st(3'h5);
            wr(sp, HOST_STATUS_OFS, 32'h0);
            st(3'h3);
            cur = PS_D2;
            st(3'h1);
            cur = PS_D0;
            ev_pulse(1);
            wr(sp, HOST_STATUS_OFS, 32'h1);
        end
        r = rnd();
        php_host_model_i.acc(1'b1, SP_IO, {4'h0, HOST_TO_DSP_CONTROL_OFS}, 4'h5, r, rd);
        chk(host_to_dsp_control, r & 32'h00ff00ff);
        php_host_model_i.acc(1'b1, SP_MEM1, {4'h0, DSP_PAGE_WINDOW_OFS}, 4'hf, ~r, rd);
        chk(dsp_page_window, ~r);
        php_host_model_i.acc(1'b0, SP_MEM1, {4'h0, HOST_RSVD_OFS}, 4'hf, 32'h0, rd);
        chk(rd, 32'h0);
        php_host_model_i.acc(1'b1, SP_MEM0, {4'h0, DSP_PAGE_WINDOW_OFS}, 4'hf, r, rd);
        chk(dsp_page_window, ~r);
        chk({24'h0, dsp_mmr_addr}, 32'h8);
        ev_pulse(2);
        chk({31'h0, wake_pin_oe}, 32'h0);
        php_host_model_i.acc(1'b1, SP_CFG, CFG_PM_CTRL_OFS, 4'h2, 32'h100, rd);
        @(posedge core_clk);
        #1;
        chk({31'h0, wake_pin_oe}, 32'h1);
        php_host_model_i.acc(1'b1, SP_CFG, CFG_PM_CTRL_OFS, 4'h2, 32'h8100, rd);
        @(posedge core_clk);
        #1;
        chk({29'h0, wake_pin_o, wake_pin_oe, host_irq_pin_o}, 32'h0);
        close_out();
    end
endmodule
